// >>> ppstg_pkg.sv
// Shared constants for the once-per-second time pulse generator
package ppstg_pkg;
  // Clock and timing figures
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned PERIOD_MS = 1000;
  localparam int unsigned HIGH_MS = 100;
  localparam int unsigned PERIOD_CYC = (CLK_HZ / 1000) * PERIOD_MS;
  localparam int unsigned HIGH_CYC = (CLK_HZ / 1000) * HIGH_MS;
  // Counter and timestamp widths
  localparam int unsigned CNT_W = 25;
  localparam int unsigned SEC_W = 32;
  // Reset values
  localparam logic RST_PULSE = 1'b0;
  localparam logic [SEC_W-1:0] RST_SECOND = 32'h0000_0000;
endpackage

// >>> ppstg_sink.sv
// External equipment model timing the pulse train
`timescale 1ns/100ps
`default_nettype none
module ppstg_sink (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Pulse pin
  input wire logic pps,
  input wire logic pvld,
  // Measurements
  output logic [15:0] period,
  output logic [15:0] high_time,
  output logic trusted
);
  logic prev;
  logic [15:0] cnt;
  logic [15:0] hcnt;
  // Edge timing; a pulse is trusted only when flagged valid
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev <= 1'b0;
      cnt <= 16'h0000;
      hcnt <= 16'h0000;
      period <= 16'h0000;
      high_time <= 16'h0000;
      trusted <= 1'b0;
    end else begin
      prev <= pps;
      cnt <= (pps && !prev) ? 16'h0001 : cnt + 16'h0001;
      hcnt <= pps ? hcnt + 16'h0001 : 16'h0000;
      if (pps && !prev) begin
        period <= cnt;
        trusted <= pvld;
      end
      if (!pps && prev) high_time <= hcnt;
    end
  end
endmodule
`default_nettype wire

// >>> ppstg_sync3.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module ppstg_sync3 #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Pin side
  input wire logic [W-1:0] pin,
  // Synchronous side
  output logic [W-1:0] level
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      logic next_level;
      // Take a change only once stages two and three agree
      always_comb begin
        next_level = (s2 == s3) ? s3 : level[i];
      end
      // Four flops, first read only by the second
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          level[i] <= 1'b0;
        end else begin
          s1 <= pin[i];
          s2 <= s1;
          s3 <= s2;
          level[i] <= next_level;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// >>> ppstg_top.sv
// Once-per-second time pulse generator with satellite second alignment
//
// Function
// RULE1 - A pulse is driven once every second, giving a one-second nominal period.
// RULE2 - Once satellite time is known, every rising edge is placed on the satellite second mark.
// RULE3 - Each pulse is high for one tenth of the period, 100 ms, then low for the rest.
// RULE4 - The pulse is flagged valid only while a full navigation solution is held.
// RULE5 - Outside equipment ignores the pulse for timing whenever no fix is reported.
// RULE6 - On start or restart one period longer or shorter than a second may occur while aligning.
// RULE7 - A timestamp message naming the absolute second accompanies each pulse.
// RULE8 - Before satellite time exists, pulses free-run at one second from the local clock.
`timescale 1ns/100ps
`default_nettype none
module ppstg_top #(
  parameter logic [ppstg_pkg::CNT_W-1:0] PERIOD_CYC = ppstg_pkg::CNT_W'(ppstg_pkg::PERIOD_CYC),
  parameter logic [ppstg_pkg::CNT_W-1:0] HIGH_CYC = ppstg_pkg::CNT_W'(ppstg_pkg::HIGH_CYC)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Receiver pins
  input wire logic sat_second_mark,
  input wire logic sat_time_known,
  input wire logic full_navigation_solution,
  // Receiver time word, same clock
  input wire logic [ppstg_pkg::SEC_W-1:0] sat_second,
  // Pulse pin
  output logic pps_out,
  output logic pps_valid,
  // Timestamp message
  output logic pulse_timestamp_message_valid,
  output logic [ppstg_pkg::SEC_W-1:0] pulse_timestamp_message_second,
  output logic pulse_timestamp_message_aligned
);
  // Synchronised pins, period counter state and next values
  logic [2:0] pin_level;
  logic mark_lvl;
  logic mark_prev;
  logic time_ok;
  logic fix_ok;
  logic mark_edge;
  logic aligned;
  logic [ppstg_pkg::CNT_W-1:0] cnt;
  logic [ppstg_pkg::CNT_W-1:0] next_cnt;
  logic next_aligned;
  logic next_pps;
  logic next_valid;
  logic next_ts_valid;
  logic [ppstg_pkg::SEC_W-1:0] next_ts_second;
  logic next_mark_prev;
  logic wrap;

  // Pins brought into the clock domain
  ppstg_sync3 #(
    .W(3)
  ) u_sync (
    .clk(clk),
    .nrst(nrst),
    .pin({full_navigation_solution, sat_time_known, sat_second_mark}),
    .level(pin_level)
  );

  assign mark_lvl = pin_level[0];
  assign time_ok = pin_level[1];
  assign fix_ok = pin_level[2];
  assign mark_edge = mark_lvl && !mark_prev;
  assign wrap = (cnt == PERIOD_CYC - 1'b1);

  // Period counter, alignment and pulse shaping
  always_comb begin
    next_mark_prev = mark_lvl;
    next_cnt = cnt;
    next_aligned = aligned;
    next_ts_valid = 1'b0;
    next_ts_second = pulse_timestamp_message_second;
    if (!time_ok) begin
      next_aligned = 1'b0; // RULE6
    end
    if (time_ok && mark_edge) begin
      next_cnt = '0; // RULE2 RULE6
      next_aligned = 1'b1;
      next_ts_valid = 1'b1; // RULE7
      next_ts_second = sat_second;
    end else if (wrap) begin
      next_cnt = '0; // RULE1 RULE8
      next_ts_valid = 1'b1; // RULE7
      next_ts_second = pulse_timestamp_message_second + 1'b1;
    end else begin
      next_cnt = cnt + 1'b1;
    end
    next_pps = (next_cnt < HIGH_CYC); // RULE3
    next_valid = fix_ok && next_aligned; // RULE4
  end

  // State and output registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= PERIOD_CYC - 1'b1; // Wraps at the first edge, so the first pulse is whole
      mark_prev <= 1'b0;
      aligned <= 1'b0;
      pps_out <= ppstg_pkg::RST_PULSE;
      pps_valid <= 1'b0;
      pulse_timestamp_message_valid <= 1'b0;
      pulse_timestamp_message_second <= ppstg_pkg::RST_SECOND;
      pulse_timestamp_message_aligned <= 1'b0;
    end else begin
      cnt <= next_cnt;
      mark_prev <= next_mark_prev;
      aligned <= next_aligned;
      pps_out <= next_pps;
      pps_valid <= next_valid;
      pulse_timestamp_message_valid <= next_ts_valid;
      pulse_timestamp_message_second <= next_ts_second;
      pulse_timestamp_message_aligned <= next_aligned;
    end
  end

  // Cycles high since the last stamp, used by the width check
  logic [ppstg_pkg::CNT_W-1:0] high_run;
  logic [ppstg_pkg::CNT_W-1:0] next_high_run;

  // Restart on a stamp, count while high, clear while low
  always_comb begin
    next_high_run = '0;
    if (pulse_timestamp_message_valid) begin
      next_high_run = ppstg_pkg::CNT_W'(1);
    end else if (pps_out) begin
      next_high_run = high_run + 1'b1;
    end
  end

  // Width helper register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      high_run <= '0;
    end else begin
      high_run <= next_high_run;
    end
  end

  // Checks
  property p_period_bound;
    @(posedge clk) disable iff (!nrst) cnt < PERIOD_CYC;
  endproperty
  a_period_bound: assert property (p_period_bound) else $error("period counter overrun"); // RULE1

  property p_align_mark;
    @(posedge clk) disable iff (!nrst) (time_ok && mark_edge) |=> (cnt == '0) && pps_out;
  endproperty
  a_align_mark: assert property (p_align_mark) else $error("edge not on second mark"); // RULE2

  property p_rise_at_zero;
    @(posedge clk) disable iff (!nrst) $rose(pps_out) |-> cnt == '0 ##1 pps_out[*8];
  endproperty
  a_rise_at_zero: assert property (p_rise_at_zero) else $error("pulse rise misplaced"); // RULE3

  property p_fall_at_high;
    @(posedge clk) disable iff (!nrst) $fell(pps_out) |-> cnt == HIGH_CYC;
  endproperty
  a_fall_at_high: assert property (p_fall_at_high) else $error("pulse width wrong"); // RULE3

  property p_valid_needs_fix;
    @(posedge clk) disable iff (!nrst) pps_valid |-> $past(fix_ok) && aligned;
  endproperty
  a_valid_needs_fix: assert property (p_valid_needs_fix) else $error("valid without fix"); // RULE4

  property p_align_only_on_mark;
    @(posedge clk) disable iff (!nrst) $rose(aligned) |-> $past(mark_edge) && $past(time_ok);
  endproperty
  a_align_only_on_mark: assert property (p_align_only_on_mark) else $error("bad realign"); // RULE6

  property p_stamp_with_pulse;
    @(posedge clk) disable iff (!nrst)
      $rose(pps_out) |-> pulse_timestamp_message_valid ##1 !pulse_timestamp_message_valid;
  endproperty
  a_stamp_with_pulse: assert property (p_stamp_with_pulse) else $error("timestamp missing"); // RULE7

  property p_free_run;
    @(posedge clk) disable iff (!nrst) (!time_ok && wrap) |=> (cnt == '0) && pps_out;
  endproperty
  a_free_run: assert property (p_free_run) else $error("free-run wrap missed"); // RULE8

  // Width, count and stamp checks
  property p_high_width;
    @(posedge clk) disable iff (!nrst) $fell(pps_out) |-> high_run == HIGH_CYC;
  endproperty
  a_high_width: assert property (p_high_width) else $error("pulse high time wrong"); // RULE3

  property p_cnt_step;
    @(posedge clk) disable iff (!nrst)
      !(time_ok && mark_edge) && !wrap |=> cnt == $past(cnt) + 1'b1;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("period counter skipped"); // RULE1

  property p_stamp_sec;
    @(posedge clk) disable iff (!nrst)
      (time_ok && mark_edge) |=> pulse_timestamp_message_second == $past(sat_second);
  endproperty
  a_stamp_sec: assert property (p_stamp_sec) else $error("aligned stamp second wrong"); // RULE7

  property p_stamp_step;
    @(posedge clk) disable iff (!nrst) (wrap && !(time_ok && mark_edge)) |=>
      pulse_timestamp_message_second == $past(pulse_timestamp_message_second) + 1'b1;
  endproperty
  a_stamp_step: assert property (p_stamp_step) else $error("free stamp not stepped"); // RULE7

  // Validity and refusal checks
  property p_mark_refused;
    @(posedge clk) disable iff (!nrst) (mark_edge && !time_ok) |=> !aligned;
  endproperty
  a_mark_refused: assert property (p_mark_refused) else $error("mark taken without time"); // RULE2

  property p_fix_drop;
    @(posedge clk) disable iff (!nrst) !fix_ok |=> !pps_valid;
  endproperty
  a_fix_drop: assert property (p_fix_drop) else $error("valid kept without fix"); // RULE4

  property p_time_drop;
    @(posedge clk) disable iff (!nrst)
      !time_ok |=> !pps_valid && !pulse_timestamp_message_aligned;
  endproperty
  a_time_drop: assert property (p_time_drop) else $error("valid kept without time"); // RULE4

  // Cover points for the main scenarios
  c_free_pulse: cover property (@(posedge clk) disable iff (!nrst) !aligned && $rose(pps_out));
  c_aligned: cover property (@(posedge clk) disable iff (!nrst) $rose(aligned));
  c_valid: cover property (@(posedge clk) disable iff (!nrst) pps_valid && $rose(pps_out));
  c_refused_mark: cover property (@(posedge clk) disable iff (!nrst) mark_edge && !time_ok);
  c_fix_lost: cover property (@(posedge clk) disable iff (!nrst) $fell(pps_valid));
endmodule
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the time pulse generator
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic mark = 1'b0;
  logic tknown = 1'b0;
  logic fix = 1'b0;
  logic [31:0] sec = 32'h0000_0000;
  logic pps, pvld, tsv, tsa, trust;
  logic [31:0] tss, s0;
  logic [15:0] per, hi;
  int fails = 0;
  int n_checks = 0;
  // 20 MHz clock
  always #25 clk = ~clk;
  ppstg_top #(.PERIOD_CYC(25'h00000c8), .HIGH_CYC(25'h0000014)) uut (
    .clk(clk), .nrst(nrst), .sat_second_mark(mark), .sat_time_known(tknown),
    .full_navigation_solution(fix), .sat_second(sec), .pps_out(pps), .pps_valid(pvld),
    .pulse_timestamp_message_valid(tsv), .pulse_timestamp_message_second(tss),
    .pulse_timestamp_message_aligned(tsa));
  ppstg_sink sink (.clk(clk), .nrst(nrst), .pps(pps), .pvld(pvld),
    .period(per), .high_time(hi), .trusted(trust));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Bounded wait for a timestamp with the given alignment
  task automatic wait_ts(input logic al);
    for (int i = 0; i < 400; i++) begin
      @(negedge clk);
      if (tsv === 1'b1 && tsa === al) return;
    end
    fails++;
    test_done();
  endtask
  task automatic free_run;
    wait_ts(1'b0);
    s0 = tss;
    // Mark while time is unknown must be ignored
    mark = 1'b1;
    repeat (8) @(negedge clk);
    mark = 1'b0;
    wait_ts(1'b0);
    chk(tss, s0 + 32'h0000_0001);
    @(negedge clk);
    chk({31'h0, tsv}, 32'h0);
    chk(32'(per), 32'h0000_00c8);
    chk(32'(hi), 32'h0000_0014);
  endtask
  task automatic align;
    tknown = 1'b1;
    fix = 1'b1;
    sec = 32'h0000_0064;
    repeat (60) @(negedge clk);
    mark = 1'b1;
    wait_ts(1'b1);
    mark = 1'b0;
    chk(tss, 32'h0000_0064);
    chk({30'h0, pps, pvld}, 32'h3);
    wait_ts(1'b1);
    chk(tss, 32'h0000_0065);
    @(negedge clk);
    chk(32'(per), 32'h0000_00c8);
    chk({31'h0, trust}, 32'h1);
  endtask
  task automatic lose_fix;
    fix = 1'b0;
    wait_ts(1'b1);
    chk({31'h0, pvld}, 32'h0);
    @(negedge clk);
    chk({31'h0, trust}, 32'h0);
  endtask
  task automatic lose_time;
    tknown = 1'b0;
    wait_ts(1'b0);
    chk(tss, 32'h0000_0067);
  endtask
  // Reset, then scenarios in order
  initial begin
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    free_run();
    align();
    lose_fix();
    lose_time();
    test_done();
  end
endmodule
`default_nettype wire
